//--- src/bla_aligner.sv
// Byte-lane aligner: alignment trap, transfer split, lane steering
// Functional notes
// - A read or write bus cycle can finish in two clocks.
// - Up to three bus cycles may be outstanding at once.
// - Misaligned data load or store traps instead of reaching the bus.
// - 128-bit access aligned only when low four address bits are zero.
// - 64-bit access aligned only on an 8-byte boundary.
// - 32-bit access aligned only when low two address bits are zero.
// - 16-bit access aligned only when lowest address bit is zero.
// - Instruction fetch addresses must have low two bits zero.
// - Dual instruction pair starts on an 8-byte boundary.
// - 64-bit is one bus transfer; 128-bit is two consecutive ones.
// - Narrow reads fetch 64 bits and shift operand down to lane 0.
// - Byte and halfword reads sign-extend to 32 bits.
// - Read cycles assert enables of the operand's byte lanes.
// - Narrow writes shift register data left onto the target lanes.
// - Shift and enables come from address low bits, size and endian mode.
// - Upper 29 address bits select the 64-bit word.
// - Big-endian mode XORs the byte offset with 7, 6 or 4 for one, two or four bytes.
// - Little-endian offset zero maps to lane 0 and enable 0.
// - Instruction fetches always use little-endian addressing.
// - Data endian resets little; only supervisor may switch it.
`timescale 1ns/100ps
`include "bla_params.svh"

module bla_aligner (
	// Clock, reset and enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Core request
	input wire logic req_valid,
	input wire bla_pkg::bla_req_s req,
	input wire logic [127:0] req_wdata,
	output logic req_ready,
	output logic trap,
	output logic trap_fetch,
	// Endian mode control
	input wire logic endian_wr,
	input wire logic endian_big_in,
	input wire logic supervisor,
	output logic endian_big,
	// Bus cycle start toward the cycle controller
	output logic xfer_start,
	output logic xfer_write,
	output logic [28:0] word_address_bus,
	output logic [7:0] byte_lane_enable_n,
	output logic [63:0] wide_data_bus_out,
	output logic wide_data_bus_oe,
	// Bus cycle completion from the cycle controller
	input wire logic xfer_done,
	input wire logic [63:0] wide_data_bus_in,
	input wire logic cache_fill_enable_n,
	// Results toward the core
	output logic rd_valid,
	output logic rd_second,
	output logic [63:0] rd_data,
	output logic [63:0] rd_line,
	output logic rd_cacheable,
	output logic wr_done
);

	// Bytes covered by a narrow operand, as a lane mask
	function automatic logic [7:0] f_lmask(input bla_pkg::bla_size_e sz);
		case (sz)
			bla_pkg::BLA_SZ8: f_lmask = `BLA_LMASK_8;
			bla_pkg::BLA_SZ16: f_lmask = `BLA_LMASK_16;
			bla_pkg::BLA_SZ32: f_lmask = `BLA_LMASK_32;
			default: f_lmask = `BLA_LMASK_ALL;
		endcase
	endfunction

	// Low address bits that must be zero for a size
	function automatic logic [3:0] f_amask(input bla_pkg::bla_size_e sz);
		case (sz)
			bla_pkg::BLA_SZ16: f_amask = `BLA_AMASK_16;
			bla_pkg::BLA_SZ32: f_amask = `BLA_AMASK_32;
			bla_pkg::BLA_SZ64: f_amask = `BLA_AMASK_64;
			bla_pkg::BLA_SZ128: f_amask = `BLA_AMASK_128;
			default: f_amask = 4'h0;
		endcase
	endfunction

	// Size that alignment and lanes use; fetches ignore the size field
	function automatic bla_pkg::bla_size_e f_esize(input logic fetch, input logic dual,
			input bla_pkg::bla_size_e sz);
		if (!fetch) begin
			f_esize = sz;
		end else if (dual) begin
			f_esize = bla_pkg::BLA_SZ64;
		end else begin
			f_esize = bla_pkg::BLA_SZ32;
		end
	endfunction

	// Lane of the operand's least significant byte
	function automatic logic [2:0] f_lane(input logic [2:0] a,
			input bla_pkg::bla_size_e sz, input logic big);
		logic [7:0] lm;
		logic [2:0] inv;
		// Flip pattern is 8-N: 7, 6 and 4 for one, two and four bytes
		lm = f_lmask(sz);
		inv = `BLA_LANE_INV & ~{1'h0, lm[2:1]};
		if (sz == bla_pkg::BLA_SZ64 || sz == bla_pkg::BLA_SZ128) begin
			f_lane = 3'h0;
		end else if (big) begin
			f_lane = a ^ inv;
		end else begin
			f_lane = a;
		end
	endfunction

	// Active-low enables for an operand at a lane
	function automatic logic [7:0] f_be_n(input logic [2:0] k,
			input bla_pkg::bla_size_e sz);
		f_be_n = ~(f_lmask(sz) << k);
	endfunction

	// Sequencer and request state
	bla_pkg::bla_state_e state_r, state_nxt;
	bla_pkg::bla_req_s op_r;
	logic [127:0] wdata_r;
	logic half_r;
	logic endian_big_r;

	// Outstanding-cycle queue
	bla_pkg::bla_tag_s tag_q [`BLA_QDEPTH];
	logic [1:0] wptr_r, rptr_r, cnt_r;

	// Output registers
	logic req_ready_r, trap_r, trap_fetch_r;
	logic xfer_start_r, xfer_write_r, oe_r;
	logic [28:0] word_r;
	logic [7:0] be_n_r;
	logic [63:0] dout_r;
	logic rd_valid_r, rd_second_r, rd_cacheable_r, wr_done_r;
	logic [63:0] rd_data_r, rd_line_r;

	// Request decode: effective size, endian and alignment
	wire bla_pkg::bla_size_e chk_size = f_esize(req.fetch, req.dual, req.size);
	wire misaligned = (req.addr[3:0] & f_amask(chk_size)) != 4'h0;
	wire accept = clk_en && req_valid && req_ready_r && state_r == bla_pkg::BLA_IDLE;
	wire take = accept && !misaligned;
	wire op_big = endian_big_r && !op_r.fetch;
	wire bla_pkg::bla_size_e op_size = f_esize(op_r.fetch, op_r.dual, op_r.size);

	// Transfer being issued: lane, enables, word and data
	wire is_quad = op_size == bla_pkg::BLA_SZ128;
	wire [2:0] iss_lane = f_lane(op_r.addr[2:0], op_size, op_big);
	wire [7:0] iss_be_n = f_be_n(iss_lane, op_size);
	wire [28:0] iss_word = op_r.addr[31:3] | {28'h0, half_r};
	wire [63:0] iss_low = half_r ? wdata_r[127:64] : wdata_r[63:0];
	wire [63:0] iss_data = iss_low << {iss_lane, 3'h0};
	wire room = cnt_r != `BLA_MAX_OUTSTANDING;
	wire start = clk_en && state_r == bla_pkg::BLA_ISSUE && room;
	wire last = !is_quad || half_r;

	// Completion decode: pop the oldest tag and align its data
	wire pop = clk_en && xfer_done && cnt_r != 2'h0;
	wire bla_pkg::bla_tag_s head = tag_q[rptr_r];
	wire [63:0] shifted = wide_data_bus_in >> {head.lane, 3'h0};
	wire sx8 = head.signx && shifted[7];
	wire sx16 = head.signx && shifted[15];
	wire [31:0] ext8 = {{24{sx8}}, shifted[7:0]};
	wire [31:0] ext16 = {{16{sx16}}, shifted[15:0]};
	wire [63:0] aligned_rd =
		head.size == bla_pkg::BLA_SZ8 ? {32'h0, ext8} :
		head.size == bla_pkg::BLA_SZ16 ? {32'h0, ext16} :
		head.size == bla_pkg::BLA_SZ32 ? {32'h0, shifted[31:0]} :
		wide_data_bus_in;

	// Queue occupancy after this cycle's start and pop
	wire [1:0] cnt_nxt = cnt_r + {1'h0, start} - {1'h0, pop};

	// Next state: issue spaced by one gap clock, quad issues twice
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bla_pkg::BLA_IDLE: begin
				if (take) begin
					state_nxt = bla_pkg::BLA_ISSUE;
				end
			end
			bla_pkg::BLA_ISSUE: begin
				if (start) begin
					state_nxt = bla_pkg::BLA_GAP;
				end
			end
			bla_pkg::BLA_GAP: begin
				state_nxt = half_r ? bla_pkg::BLA_ISSUE : bla_pkg::BLA_IDLE;
			end
			default: begin
				state_nxt = bla_pkg::BLA_IDLE;
			end
		endcase
		if (!clk_en) begin
			state_nxt = state_r;
		end
	end

	// Sequencer state and ready flag
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= bla_pkg::BLA_IDLE;
			req_ready_r <= 1'h0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			req_ready_r <= state_nxt == bla_pkg::BLA_IDLE;
		end
	end

	// Latch an accepted aligned request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op_r <= '0;
			wdata_r <= 128'h0;
		end else if (take) begin
			op_r <= req;
			wdata_r <= req_wdata;
		end
	end

	// Half flag: set after the low word of a quad is issued
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			half_r <= 1'h0;
		end else if (take) begin
			half_r <= 1'h0;
		end else if (start) begin
			half_r <= !last;
		end
	end

	// Trap pulse on a misaligned access
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trap_r <= 1'h0;
			trap_fetch_r <= 1'h0;
		end else if (clk_en) begin
			trap_r <= accept && misaligned;
			trap_fetch_r <= accept && misaligned && req.fetch;
		end
	end

	// Endian mode, changed only from supervisor level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			endian_big_r <= `BLA_RST_ENDIAN_BIG;
		end else if (clk_en && endian_wr && supervisor) begin
			endian_big_r <= endian_big_in;
		end
	end

	// Bus transfer outputs; start pulses one clock, the rest held until the next start
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			xfer_start_r <= 1'h0;
			xfer_write_r <= 1'h0;
			word_r <= 29'h0;
			be_n_r <= `BLA_RST_BE_N;
			dout_r <= 64'h0;
		end else if (clk_en) begin
			xfer_start_r <= start;
			if (start) begin
				xfer_write_r <= op_r.write;
				word_r <= iss_word;
				be_n_r <= iss_be_n;
				dout_r <= iss_data;
			end
		end
	end

	// Data bus drive: on from a write start until a read start or the queue drains
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oe_r <= 1'h0;
		end else if (clk_en) begin
			if (start) begin
				oe_r <= op_r.write;
			end else if (cnt_nxt == 2'h0) begin
				oe_r <= 1'h0;
			end
		end
	end

	// Queue pointers and count of outstanding cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r <= 2'h0;
			rptr_r <= 2'h0;
			cnt_r <= 2'h0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
			if (start) begin
				wptr_r <= wptr_r == `BLA_QLAST ? 2'h0 : wptr_r + 2'h1;
			end
			if (pop) begin
				rptr_r <= rptr_r == `BLA_QLAST ? 2'h0 : rptr_r + 2'h1;
			end
		end
	end

	// Queue storage, written at each start
	always_ff @(posedge clock) begin
		if (start) begin
			tag_q[wptr_r] <= '{lane: iss_lane, size: op_size,
				signx: op_r.signx, write: op_r.write, second: half_r};
		end
	end

	// Completion results; the raw line keeps all eight lanes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_r <= 1'h0;
			rd_second_r <= 1'h0;
			rd_cacheable_r <= 1'h0;
			wr_done_r <= 1'h0;
			rd_data_r <= 64'h0;
			rd_line_r <= 64'h0;
		end else if (clk_en) begin
			rd_valid_r <= pop && !head.write;
			wr_done_r <= pop && head.write;
			if (pop && !head.write) begin
				rd_second_r <= head.second;
				rd_data_r <= aligned_rd;
				rd_line_r <= wide_data_bus_in;
				rd_cacheable_r <= !cache_fill_enable_n;
			end
		end
	end

	// Ports straight from flip-flops
	assign req_ready = req_ready_r;
	assign trap = trap_r;
	assign trap_fetch = trap_fetch_r;
	assign endian_big = endian_big_r;
	assign xfer_start = xfer_start_r;
	assign xfer_write = xfer_write_r;
	assign word_address_bus = word_r;
	assign byte_lane_enable_n = be_n_r;
	assign wide_data_bus_out = dout_r;
	assign wide_data_bus_oe = oe_r;
	assign rd_valid = rd_valid_r;
	assign rd_second = rd_second_r;
	assign rd_data = rd_data_r;
	assign rd_line = rd_line_r;
	assign rd_cacheable = rd_cacheable_r;
	assign wr_done = wr_done_r;

endmodule

//--- src/bla_params.svh
// Constants for the byte-lane aligner: masks, limits and timing
`ifndef BLA_PARAMS_SVH
`define BLA_PARAMS_SVH
// Clock period in ns and the shortest bus cycle in clocks
`define BLA_CLK_PERIOD_NS 8
`define BLA_MIN_CYCLE_CLKS 2
// Most bus cycles that may be outstanding at once
`define BLA_MAX_OUTSTANDING 2'h3
// Queue depth and last index
`define BLA_QDEPTH 3
`define BLA_QLAST 2'h2
// Low address bits that must be zero per operand size
`define BLA_AMASK_16 4'h1
`define BLA_AMASK_32 4'h3
`define BLA_AMASK_64 4'h7
`define BLA_AMASK_128 4'hf
// Lane masks for the narrow sizes, lane 0 in bit 0
`define BLA_LMASK_8 8'h01
`define BLA_LMASK_16 8'h03
`define BLA_LMASK_32 8'h0f
`define BLA_LMASK_ALL 8'hff
// Offset inversion pattern used in big-endian mode
`define BLA_LANE_INV 3'h7
// Reset values
`define BLA_RST_BE_N 8'hff
`define BLA_RST_ENDIAN_BIG 1'h0
`endif

//--- src/bla_pkg.sv
// Types shared by the byte-lane aligner
package bla_pkg;
	// Operand size of an access
	typedef enum logic [2:0] {
		BLA_SZ8 = 3'h0,
		BLA_SZ16 = 3'h1,
		BLA_SZ32 = 3'h2,
		BLA_SZ64 = 3'h3,
		BLA_SZ128 = 3'h4
	} bla_size_e;
	// Sequencer states, Gray along idle, issue, gap
	typedef enum logic [1:0] {
		BLA_IDLE = 2'h0,
		BLA_ISSUE = 2'h1,
		BLA_GAP = 2'h3
	} bla_state_e;
	// Access request from the core
	typedef struct packed {
		logic [31:0] addr;
		bla_size_e size;
		logic write;
		logic fetch;
		logic dual;
		logic signx;
	} bla_req_s;
	// Per-transfer record kept while a bus cycle is outstanding
	typedef struct packed {
		logic [2:0] lane;
		bla_size_e size;
		logic signx;
		logic write;
		logic second;
	} bla_tag_s;
endpackage

//--- test/bla_aligner_chk.sv
// Assertion checker for the byte-lane aligner
`timescale 1ns/100ps
module bla_aligner_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Request side
	input wire logic clk_en,
	input wire logic req_valid,
	input wire bla_pkg::bla_req_s req,
	input wire logic req_ready,
	input wire logic trap,
	input wire logic endian_wr,
	input wire logic supervisor,
	input wire logic endian_big,
	// Bus side
	input wire logic xfer_start,
	input wire logic [7:0] byte_lane_enable_n,
	input wire logic xfer_done,
	input wire logic rd_valid,
	input wire logic wr_done
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [2:0] out_r;
	logic [3:0] amask;
	logic take;
	logic mis;
	// Low address bits that must be zero; fetches by the pair flag
	assign amask = req.fetch ? (req.dual ? 4'h7 : 4'h3) : 4'hf >> (3'h4 - 3'(req.size));
	assign take = clk_en && req_valid && req_ready;
	assign mis = (req.addr[3:0] & amask) != 4'h0;
	// Bus cycles still waiting for completion
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= 3'h0;
		end else if (clk_en) begin
			out_r <= out_r + 3'(xfer_start) - 3'(xfer_done && out_r != 3'h0);
		end
	end
	a_misal_trap: assert property (take && mis |=> trap && !xfer_start ##1 !xfer_start)
		else $error("misaligned request not trapped");
	a_align_go: assert property (take && !mis |=> !trap ##[1:30] xfer_start)
		else $error("aligned request not issued");
	a_lane_shape: assert property (xfer_start |-> $onehot(~byte_lane_enable_n)
		|| ~byte_lane_enable_n inside {8'h03, 8'h0c, 8'h30, 8'hc0, 8'h0f, 8'hf0, 8'hff})
		else $error("lane enables not a legal group");
	a_depth_limit: assert property (out_r <= 3'h3)
		else $error("more than three cycles outstanding");
	a_start_gap: assert property (xfer_start |=> !xfer_start)
		else $error("bus starts too close");
	a_done_answer: assert property (xfer_done && out_r != 3'h0 |=> rd_valid ^ wr_done)
		else $error("completion not answered");
	a_endian_hold: assert property (endian_wr && !supervisor |=> $stable(endian_big))
		else $error("endian changed without supervisor");
	a_quad_two: assert property (take && !mis && !req.fetch && req.size == bla_pkg::BLA_SZ128
		|-> ##[2:30] xfer_start ##[2:30] xfer_start)
		else $error("quad access not two transfers");
	c_trap: cover property (trap);
	c_deep: cover property (out_r == 3'h3);
	c_big: cover property (endian_big);
endmodule

bind bla_aligner bla_aligner_chk u_chk (.*);

//--- test/bla_mem_model.sv
// Memory and cycle-controller model on the far side of the aligner
`timescale 1ns/100ps
module bla_mem_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Bus cycle from the aligner
	input wire logic xfer_start,
	input wire logic xfer_write,
	input wire logic [28:0] word_address_bus,
	input wire logic [7:0] byte_lane_enable_n,
	input wire logic [63:0] wide_data_bus_out,
	// Scenario controls
	input wire logic [3:0] delay,
	input wire logic nocache,
	// Completion toward the aligner
	output logic xfer_done,
	output logic [63:0] wide_data_bus_in,
	output logic cache_fill_enable_n
);
	logic [63:0] mem [16];
	logic [76:0] q [$];
	logic [76:0] h;
	int w;
	// Cycles finish in order after the set delay; idle data bus toggles
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			xfer_done <= 1'b0;
			cache_fill_enable_n <= 1'b1;
			wide_data_bus_in <= 64'h0;
			q.delete();
			w = 0;
		end else begin
			xfer_done <= 1'b0;
			wide_data_bus_in <= ~wide_data_bus_in;
			if (xfer_start)
				q.push_back({xfer_write, byte_lane_enable_n, word_address_bus[3:0], wide_data_bus_out});
			if (q.size() != 0 && w >= delay) begin
				h = q.pop_front();
				w = 0;
				xfer_done <= 1'b1;
				cache_fill_enable_n <= nocache;
				wide_data_bus_in <= mem[h[67:64]];
				for (int i = 0; i < 8; i++)
					if (h[76] && !h[68 + i]) mem[h[67:64]][8 * i +: 8] = h[8 * i +: 8];
			end else if (q.size() != 0) begin
				w++;
			end
		end
	end
endmodule

//--- test/test_bla_aligner.sv
// Testbench for the byte-lane aligner
`timescale 1ns/100ps
module test_bla_aligner;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic req_valid = 1'b0;
	bla_pkg::bla_req_s req = '0;
	logic [127:0] req_wdata = '0;
	logic endian_wr = 1'b0;
	logic endian_big_in = 1'b0;
	logic supervisor = 1'b0;
	logic [3:0] delay = 4'h0;
	logic nocache = 1'b0;
	logic req_ready, trap, trap_fetch, endian_big, xfer_start, xfer_write, wide_data_bus_oe;
	logic [28:0] word_address_bus;
	logic [7:0] byte_lane_enable_n;
	logic [63:0] wide_data_bus_out, wide_data_bus_in, rd_data, rd_line;
	logic xfer_done, cache_fill_enable_n, rd_valid, rd_second, rd_cacheable, wr_done;
	int n_fail = 0;
	int compares = 0;
	int n_trap, n_tf, n_start, n_done;
	logic [1:0] wr0;
	logic mode = 1'b0;
	logic [7:0] be0;
	logic [28:0] wa0;
	logic [63:0] rdq [2];

	bla_aligner u_dut (.*);
	bla_mem_model u_mem (.*);

	always #4 clock = ~clock;

	// Record what the design shows during each scenario
	always @(posedge clock) begin
		if (trap) n_trap++;
		if (trap_fetch) n_tf++;
		if (xfer_start && n_start == 0) wr0 = {xfer_write, wide_data_bus_oe};
		if (rd_valid || wr_done) n_done++;
		if (rd_valid) rdq[rd_second] = rd_data;
		if (xfer_start && n_start == 0) be0 = byte_lane_enable_n;
		if (xfer_start && n_start == 0) wa0 = word_address_bus;
		if (xfer_start) n_start++;
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One request, flags are write, fetch, dual, sign
	task automatic send(input logic [31:0] a, input bla_pkg::bla_size_e sz, input logic [3:0] f,
		input logic [127:0] wd);
		int i;
		for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clock);
		if (i == 50) begin
			n_fail++;
			end_sim();
		end
		req <= '{a, sz, f[3], f[2], f[1], f[0]};
		req_wdata <= wd;
		req_valid <= 1'b1;
		@(negedge clock);
		req_valid <= 1'b0;
	endtask

	// Request, wait for its outcome and judge trap, lanes, address and data
	task automatic acc(input logic [31:0] a, input bla_pkg::bla_size_e sz, input logic [3:0] f,
		input logic [127:0] wd);
		int n, k, nt, i;
		logic bad;
		logic [3:0] ix;
		logic [7:0] ebe;
		logic [63:0] m, old, ex;
		n = f[2] ? (f[1] ? 8 : 4) : 1 << sz;
		bad = (a[3:0] & 4'(n - 1)) != 4'h0;
		k = n > 4 ? 0 : (mode && !f[2]) ? a[2:0] ^ (8 - n) : a[2:0];
		m = n > 4 ? '1 : ((64'h1 << 8 * n) - 1) << 8 * k;
		for (i = 0; i < 8; i++) ebe[i] = ~m[8 * i];
		nt = bad ? 0 : (n == 16 ? 2 : 1);
		ix = a[6:3];
		old = u_mem.mem[ix];
		n_trap = 0;
		n_tf = 0;
		n_start = 0;
		n_done = 0;
		send(a, sz, f, wd);
		for (i = 0; i < 60 && !((bad ? n_trap : n_done) == (bad ? 1 : nt) && req_ready); i++)
			@(negedge clock);
		if (i == 60) begin
			n_fail++;
			end_sim();
		end
		chk("trap", bad, n_trap);
		chk("trap fetch", bad && f[2], n_tf);
		chk("starts", nt, n_start);
		if (bad) return;
		chk("enables", ebe, be0);
		chk("word", a[31:3], wa0);
		chk("write", {2{f[3]}}, wr0);
		if (f[3]) begin
			ex = (old & ~m) | ((wd[63:0] << 8 * k) & m);
			chk("memory", ex, u_mem.mem[ix]);
			if (n == 16) chk("memory hi", wd[127:64], u_mem.mem[ix + 1]);
		end else begin
			ex = (old & m) >> 8 * k;
			if (f[0] && n < 4 && ex[8 * n - 1]) ex[31:0] = ex[31:0] | ~((32'h1 << 8 * n) - 1);
			chk("read", ex, rdq[0]);
			if (n == 16) chk("read hi", u_mem.mem[ix + 1], rdq[1]);
			chk("line", n == 16 ? u_mem.mem[ix + 1] : old, rd_line);
			chk("cacheable", 1'b1, rd_cacheable);
		end
	endtask

	task automatic set_endian(input logic big, input logic sup);
		endian_big_in <= big;
		supervisor <= sup;
		endian_wr <= 1'b1;
		@(negedge clock);
		endian_wr <= 1'b0;
		if (sup) mode = big;
		@(negedge clock);
		chk("endian", mode, endian_big);
	endtask

	// Misaligned and aligned data of 16, 32, 64 and 128 bits, then fetches
	task automatic t_align();
		for (int s = 1; s < 5; s++) begin
			acc(32'h40 + (1 << s) / 2, bla_pkg::bla_size_e'(s), 4'h0, '0);
			acc(32'h40 + (1 << s), bla_pkg::bla_size_e'(s), 4'h0, '0);
		end
		acc(32'h82, bla_pkg::BLA_SZ32, 4'h4, '0);
		acc(32'h84, bla_pkg::BLA_SZ32, 4'h6, '0);
		acc(32'h88, bla_pkg::BLA_SZ32, 4'h6, '0);
	endtask

	// Every lane for narrow sizes, wide and quad, in both endian modes
	task automatic t_lanes();
		for (int b = 0; b < 2; b++) begin
			set_endian(b[0], 1'b0);
			set_endian(b[0], 1'b1);
			for (int s = 0; s < 3; s++)
				for (int o = 0; o < 8; o += 1 << s) begin
					acc(32'h100 + o, bla_pkg::bla_size_e'(s), 4'h1, '0);
					acc(32'h108 + o, bla_pkg::bla_size_e'(s), 4'h8, 128'h8899aabb);
				end
			acc(32'h134, bla_pkg::BLA_SZ8, 4'h4, '0);
			acc(32'h110, bla_pkg::BLA_SZ64, 4'h8, 128'h0f1e2d3c4b5a6978);
			acc(32'h120, bla_pkg::BLA_SZ128, 4'h8, {64'h0123456789abcdef, 64'hfedcba9876543210});
			acc(32'h120, bla_pkg::BLA_SZ128, 4'h0, '0);
		end
	endtask

	// Slow far side so three cycles stay outstanding; fill refused
	task automatic t_pipe();
		int i;
		delay = 4'hc;
		nocache = 1'b1;
		n_done = 0;
		for (i = 0; i < 4; i++) send(32'h1c0 + 8 * i, bla_pkg::BLA_SZ64, 4'h0, '0);
		for (i = 0; i < 100 && n_done < 4; i++) @(negedge clock);
		chk("done count", 4, n_done);
		chk("last read", u_mem.mem[4'hb], rdq[0]);
		chk("cacheable", 1'b0, rd_cacheable);
		delay = 4'h0;
		nocache = 1'b0;
	endtask

	initial begin
		for (int i = 0; i < 16; i++) u_mem.mem[i] = 64'hf1627354b5a61788 + i;
		repeat (8) @(negedge clock);
		chk("enables rst", 8'hff, byte_lane_enable_n);
		chk("endian rst", 1'b0, endian_big);
		rst_n = 1'b1;
		t_align();
		t_lanes();
		t_pipe();
		end_sim();
	end
endmodule
